// file: hdl/oad_defines.vh
`ifndef OAD_DEFINES_VH
`define OAD_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OAD_ADDR_W      8
`define OAD_OFS_CTRL    8'h00
`define OAD_OFS_STREAM  8'h04
`define OAD_OFS_BASE    8'h08
`define OAD_OFS_FRAME   8'h0c
`define OAD_OFS_SRCIDX  8'h10
`define OAD_OFS_DSTIDX  8'h14
`define OAD_OFS_FLAGS   8'h18
`define OAD_OFS_STATUS  8'h1c
`define OAD_OFS_RESULT  8'h20
`define OAD_OFS_DECODE  8'h24

// ************************************************************
// control fields
// ************************************************************
`define OAD_CTRL_WORD     0
`define OAD_CTRL_SEGMOVE  1
`define OAD_CTRL_RESTART  2

// ************************************************************
// result fields
// ************************************************************
`define OAD_RES_REGOP     16
`define OAD_RES_DONE      17
`define OAD_RES_NB_LO     18
`define OAD_RES_ILLEGAL   20

// ************************************************************
// addressing kinds and special codes
// ************************************************************
`define OAD_KIND_NOOFS    2'h0
`define OAD_KIND_OFS8     2'h1
`define OAD_KIND_OFS16    2'h2
`define OAD_KIND_REG      2'h3
`define OAD_SEL_DIRECT    3'h6
`define OAD_SEG_CODE      2'h1

// ************************************************************
// reset values and bus answers
// ************************************************************
`define OAD_RST16         16'h0000
`define OAD_RST_FLAGS     9'h000
`define OAD_RST_CTRL      2'h0
`define OAD_RESP_OKAY     2'h0
`define OAD_RESP_SLVERR   2'h2

`endif

// file: hdl/oad_operand_decoder.v
// What this block does
// - kind 00 gives zero offset, no bytes except with selector 110 (two)
// - kind 01 sign-extends one low offset byte
// - kind 10 joins high above low byte
// - kind 11 selects a register, not memory
// - selectors 000-011 add base/frame plus index
// - selectors 100-111 use one register plus offset
// - kind 00 selector 110 is direct address
// - offset bytes follow second byte, before data
// - status word packs flags at fixed bits
// - register codes name word or byte registers
// - word bit picks 16-bit or 8-bit set
// - segment codes select extra, code, stack, data
`timescale 1ns/1ps
`include "oad_defines.vh"

module oad_operand_decoder (
  // clock and reset
  input  wire                   sys_clk,
  input  wire                   rst_n,
  // axi4-lite write address and data
  input  wire [`OAD_ADDR_W-1:0] s_axi_awaddr,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]             s_axi_bresp,
  output reg                    s_axi_bvalid,
  input  wire                   s_axi_bready,
  // axi4-lite read
  input  wire [`OAD_ADDR_W-1:0] s_axi_araddr,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output reg  [31:0]            s_axi_rdata,
  output reg  [1:0]             s_axi_rresp,
  output reg                    s_axi_rvalid,
  input  wire                   s_axi_rready,
  // decode results
  output reg  [15:0]            operandLocation,
  output reg  [1:0]             offsetBytes,
  output reg                    regOperand,
  output reg                    decodeDone,
  output reg                    illegalInstr,
  output reg  [15:0]            rmRegSel,
  output reg  [15:0]            regFieldSel,
  output reg  [3:0]             segSel,
  output wire [15:0]            statusWord
);

  // ************************************************************
  // sequencer states
  // ************************************************************
  localparam [4:0] S_OPC  = 5'h01;
  localparam [4:0] S_ADDR = 5'h02;
  localparam [4:0] S_LO   = 5'h04;
  localparam [4:0] S_HI   = 5'h08;
  localparam [4:0] S_DONE = 5'h10;

  // ************************************************************
  // functions
  // ************************************************************
  // low byte of the one-hot: word set, high byte: byte set
  function [15:0] regDecode;
    input [2:0] code;
    input       wordBit;
    begin
      regDecode = wordBit ? (16'h0001 << code) : (16'h0100 << code);
    end
  endfunction

  function [1:0] needBytes;
    input [7:0] addrByte;
    begin
      case (addrByte[7:6])
        `OAD_KIND_NOOFS: needBytes = (addrByte[2:0] == `OAD_SEL_DIRECT) ? 2'h2 : 2'h0;
        `OAD_KIND_OFS8:  needBytes = 2'h1;
        `OAD_KIND_OFS16: needBytes = 2'h2;
        default:         needBytes = 2'h0;
      endcase
    end
  endfunction

  function [31:0] applyStrb;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer      i;
    begin
      applyStrb = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) applyStrb[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // ************************************************************
  // register state
  // ************************************************************
  reg  [1:0]  ctrl_q;
  reg  [15:0] baseWord_q;
  reg  [15:0] framePtr_q;
  reg  [15:0] srcIndex_q;
  reg  [15:0] dstIndex_q;
  reg  [8:0]  flags_q;
  reg  [4:0]  state_q;
  reg  [7:0]  addrByte_q;
  reg  [7:0]  offsetLo_q;
  reg  [7:0]  offsetHi_q;
  reg  [15:0] offset_d;
  reg  [15:0] base_d;
  reg  [15:0] location_d;
  reg  [31:0] rdata_d;
  reg         rhit_d;
  reg         whit_d;
  wire        wrTake;
  wire        rdTake;
  wire [31:0] wMerged;
  wire        streamWr;
  wire        restartWr;
  wire [7:0]  streamByte;

  // ************************************************************
  // bus handshakes
  // ************************************************************
  // address and data are taken together; a lone one waits for its partner
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ~s_axi_rvalid & ~wrTake; // a write wins: the strobe merge shares the read mux
  assign wrTake        = s_axi_awready;
  assign rdTake        = s_axi_arvalid & s_axi_arready;
  assign streamWr      = wrTake & (s_axi_awaddr == `OAD_OFS_STREAM) & s_axi_wstrb[0];
  assign restartWr     = wrTake & (s_axi_awaddr == `OAD_OFS_CTRL) & s_axi_wstrb[0] &
                         s_axi_wdata[`OAD_CTRL_RESTART];
  assign streamByte    = s_axi_wdata[7:0];

  always @* whit_d = (s_axi_awaddr[1:0] == 2'h0) && (s_axi_awaddr <= `OAD_OFS_FLAGS);

  // ************************************************************
  // register writes
  // ************************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q       <= `OAD_RST_CTRL;
      baseWord_q   <= `OAD_RST16;
      framePtr_q   <= `OAD_RST16;
      srcIndex_q   <= `OAD_RST16;
      dstIndex_q   <= `OAD_RST16;
      flags_q      <= `OAD_RST_FLAGS;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `OAD_RESP_OKAY;
    end else begin
      if (wrTake) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= whit_d ? `OAD_RESP_OKAY : `OAD_RESP_SLVERR;
        case (s_axi_awaddr)
          `OAD_OFS_CTRL:   ctrl_q     <= wMerged[1:0];
          `OAD_OFS_BASE:   baseWord_q <= wMerged[15:0];
          `OAD_OFS_FRAME:  framePtr_q <= wMerged[15:0];
          `OAD_OFS_SRCIDX: srcIndex_q <= wMerged[15:0];
          `OAD_OFS_DSTIDX: dstIndex_q <= wMerged[15:0];
          `OAD_OFS_FLAGS:  flags_q    <= wMerged[8:0];
          default: ;
        endcase
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  assign wMerged = applyStrb(rdata_d, s_axi_wdata, s_axi_wstrb);

  // ************************************************************
  // instruction byte sequencer
  // ************************************************************
  // offset bytes are the ones right after the addressing byte; later
  // immediate bytes fall into the done state and are not decoded
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= S_OPC;
      addrByte_q <= 8'h00;
      offsetLo_q <= 8'h00;
      offsetHi_q <= 8'h00;
    end else if (restartWr) begin
      state_q <= S_OPC;
    end else if (streamWr) begin
      case (state_q)
        S_OPC: state_q <= S_ADDR;
        S_ADDR: begin
          addrByte_q <= streamByte;
          offsetLo_q <= 8'h00;
          offsetHi_q <= 8'h00;
          state_q    <= (needBytes(streamByte) == 2'h0) ? S_DONE : S_LO;
        end
        S_LO: begin
          offsetLo_q <= streamByte;
          state_q    <= (needBytes(addrByte_q) == 2'h2) ? S_HI : S_DONE;
        end
        S_HI: begin
          offsetHi_q <= streamByte;
          state_q    <= S_DONE;
        end
        S_DONE: state_q <= S_DONE;
        default: state_q <= S_OPC;
      endcase
    end
  end

  // ************************************************************
  // operand location
  // ************************************************************
  always @* begin
    case (addrByte_q[7:6])
      `OAD_KIND_OFS8:  offset_d = {{8{offsetLo_q[7]}}, offsetLo_q};
      `OAD_KIND_OFS16: offset_d = {offsetHi_q, offsetLo_q};
      default:         offset_d = 16'h0000;
    endcase
    case (addrByte_q[2:0])
      3'h0:    base_d = baseWord_q + srcIndex_q;
      3'h1:    base_d = baseWord_q + dstIndex_q;
      3'h2:    base_d = framePtr_q + srcIndex_q;
      3'h3:    base_d = framePtr_q + dstIndex_q;
      3'h4:    base_d = srcIndex_q;
      3'h5:    base_d = dstIndex_q;
      3'h6:    base_d = framePtr_q;
      default: base_d = baseWord_q;
    endcase
    if (addrByte_q[7:6] == `OAD_KIND_NOOFS && addrByte_q[2:0] == `OAD_SEL_DIRECT) begin
      location_d = {offsetHi_q, offsetLo_q};
    end else begin
      location_d = base_d + offset_d;
    end
  end

  // ************************************************************
  // decode outputs
  // ************************************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      operandLocation <= `OAD_RST16;
      offsetBytes     <= 2'h0;
      regOperand      <= 1'b0;
      decodeDone      <= 1'b0;
      illegalInstr    <= 1'b0;
      rmRegSel        <= 16'h0000;
      regFieldSel     <= 16'h0000;
      segSel          <= 4'h0;
    end else begin
      decodeDone      <= (state_q == S_DONE);
      offsetBytes     <= needBytes(addrByte_q);
      regOperand      <= (addrByte_q[7:6] == `OAD_KIND_REG);
      operandLocation <= (addrByte_q[7:6] == `OAD_KIND_REG) ? 16'h0000 : location_d;
      rmRegSel        <= (addrByte_q[7:6] == `OAD_KIND_REG) ?
                         regDecode(addrByte_q[2:0], ctrl_q[`OAD_CTRL_WORD]) : 16'h0000;
      regFieldSel     <= regDecode(addrByte_q[5:3], ctrl_q[`OAD_CTRL_WORD]);
      segSel          <= 4'h1 << addrByte_q[4:3];
      illegalInstr    <= (state_q == S_DONE) & ctrl_q[`OAD_CTRL_SEGMOVE] &
                         (addrByte_q[4:3] == `OAD_SEG_CODE);
    end
  end

  // overflow,direction,interrupt,trap,sign,zero,-,aux,-,parity,-,carry
  assign statusWord = {4'h0, flags_q[8:3], 1'b0, flags_q[2], 1'b0, flags_q[1], 1'b0, flags_q[0]};

  // ************************************************************
  // register reads
  // ************************************************************
  always @* begin
    rhit_d  = 1'b1;
    rdata_d = 32'h00000000;
    case (rdTake ? s_axi_araddr : s_axi_awaddr)
      `OAD_OFS_CTRL:   rdata_d = {30'h0, ctrl_q};
      `OAD_OFS_STREAM: rdata_d = 32'h00000000;
      `OAD_OFS_BASE:   rdata_d = {16'h0000, baseWord_q};
      `OAD_OFS_FRAME:  rdata_d = {16'h0000, framePtr_q};
      `OAD_OFS_SRCIDX: rdata_d = {16'h0000, srcIndex_q};
      `OAD_OFS_DSTIDX: rdata_d = {16'h0000, dstIndex_q};
      `OAD_OFS_FLAGS:  rdata_d = {23'h0, flags_q};
      `OAD_OFS_STATUS: rdata_d = {16'h0000, statusWord};
      `OAD_OFS_RESULT: rdata_d = {11'h0, illegalInstr, offsetBytes, decodeDone, regOperand, operandLocation};
      `OAD_OFS_DECODE: rdata_d = {4'h0, segSel, addrByte_q, offsetHi_q, offsetLo_q};
      default:         rhit_d  = 1'b0;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `OAD_RESP_OKAY;
    end else if (rdTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdata_d;
      s_axi_rresp  <= rhit_d ? `OAD_RESP_OKAY : `OAD_RESP_SLVERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

endmodule

// file: test/oad_assertions.sv
`timescale 1ns/1ps

module oad_assertions (
  // clock and reset
  input logic        sys_clk,
  input logic        rst_n,
  // bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_wvalid,
  input logic        s_axi_awready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  // decode results
  input logic [15:0] operandLocation,
  input logic [1:0]  offsetBytes,
  input logic        regOperand,
  input logic        decodeDone,
  input logic        illegalInstr,
  input logic [15:0] rmRegSel,
  input logic [15:0] regFieldSel,
  input logic [3:0]  segSel,
  input logic [15:0] statusWord
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  // ************
  // bus
  // ************
  chk_write_resp: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered");
  chk_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  chk_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");

  // ************
  // decode
  // ************
  chk_reg_mode: assert property (regOperand |-> operandLocation == 16'h0 && offsetBytes == 2'h0 && $onehot(rmRegSel))
    else $error("register mode output wrong");
  chk_mem_nosel: assert property (!regOperand |-> rmRegSel == 16'h0)
    else $error("register selected in memory mode");
  chk_field_sel: assert property (decodeDone |-> $onehot(regFieldSel) && $onehot(segSel))
    else $error("selector not one-hot");
  chk_ill_code: assert property (illegalInstr |-> decodeDone && segSel == 4'h2)
    else $error("illegal without code segment");
  chk_flag_gaps: assert property (statusWord[15:12] == 4'h0 && !statusWord[5] && !statusWord[3] && !statusWord[1])
    else $error("unused status bit set");

  cov_reg_mode: cover property (regOperand);
  cov_illegal: cover property (illegalInstr);
  cov_direct: cover property (decodeDone && offsetBytes == 2'h2);
endmodule

bind oad_operand_decoder oad_assertions oad_assertions_inst (
  .sys_clk(sys_clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .operandLocation(operandLocation), .offsetBytes(offsetBytes), .regOperand(regOperand),
  .decodeDone(decodeDone), .illegalInstr(illegalInstr), .rmRegSel(rmRegSel),
  .regFieldSel(regFieldSel), .segSel(segSel), .statusWord(statusWord)
);

// file: test/testbench.sv
`timescale 1ns/1ps
`include "oad_defines.vh"

module testbench;
  // ************
  // design ports
  // ************
  logic                   sys_clk, rst_n;
  logic [`OAD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]            s_axi_wdata, s_axi_rdata;
  logic [3:0]             s_axi_wstrb, segSel;
  logic [1:0]             s_axi_bresp, s_axi_rresp, offsetBytes;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                   s_axi_rvalid, s_axi_rready, regOperand, decodeDone, illegalInstr;
  logic [15:0]            operandLocation, rmRegSel, regFieldSel, statusWord;
  // ************
  // bench state
  // ************
  integer      n_fail, n_compared, seed, k;
  logic [33:0] expQ[$];
  logic [31:0] rv, rv2;
  logic [15:0] bx, bp, si, di, loc;
  logic [7:0]  lo, hi;
  logic [2:0]  rm, rg;
  logic [1:0]  kind, nb;
  logic        w, mv, ill;

  oad_operand_decoder oad_operand_decoder_inst (.*);

  always #4 sys_clk = ~sys_clk;

  task end_sim;
    begin
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0 && expQ.size() == 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask

  task check(input logic [33:0] seen, input logic [33:0] exp, input string nm);
    begin
      n_compared++;
      if (seen !== exp) begin
        n_fail++;
        $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask

  // bounded wait: a hang ends the run
  task tick(inout integer i);
    begin
      @(posedge sys_clk);
      i = i + 1;
      if (i > 64) begin
        n_fail++;
        $display("unexpected handshake expected 1 seen 0");
        end_sim;
      end
    end
  endtask

  // bready and rready stay high, so no answer is ever stalled
  task axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    integer i;
    begin
      i = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      do tick(i); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      do tick(i); while (s_axi_bvalid !== 1'b1);
      check(s_axi_bresp, r, "bresp");
    end
  endtask

  task axiRead(input logic [7:0] a, input logic [33:0] e);
    integer i;
    begin
      i = 0;
      expQ.push_back(e);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      do tick(i); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do tick(i); while (s_axi_rvalid !== 1'b1);
    end
  endtask

  task push(input logic [7:0] b);
    axiWrite(`OAD_OFS_STREAM, {24'h0, b}, `OAD_RESP_OKAY);
  endtask

  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      if (expQ.size() > 0) begin
        check({s_axi_rresp, s_axi_rdata}, expQ.pop_front(), "rdata");
      end else begin
        n_fail++;
        $display("unexpected rdata expected none seen %h", s_axi_rdata);
      end
    end
  end

  initial begin
    n_fail = 0;
    n_compared = 0;
    seed = 32'h065f;
    sys_clk = 1'b0;
    rst_n = 1'b0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    axiRead(`OAD_OFS_RESULT, 34'h0);
    axiRead(`OAD_OFS_CTRL, 34'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++) begin
      rv = $random(seed);
      axiWrite(`OAD_OFS_FLAGS, rv & 32'h1ff, `OAD_RESP_OKAY);
      axiRead(`OAD_OFS_STATUS, {22'h0, rv[8:3], 1'b0, rv[2], 1'b0, rv[1], 1'b0, rv[0]});
    end
    // a single byte lane must leave the other bytes alone
    axiWrite(`OAD_OFS_BASE, 32'h00001234, `OAD_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    axiWrite(`OAD_OFS_BASE, 32'hffffffcd, `OAD_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    axiRead(`OAD_OFS_BASE, 34'h0000012cd);
    axiWrite(8'h40, 32'h0, `OAD_RESP_SLVERR);
    axiRead(8'h40, {`OAD_RESP_SLVERR, 32'h0});
    $display("test flags done");
    // every kind and selector, then random extras; sums often wrap
    for (k = 0; k < 40; k++) begin
      rv = $random(seed);
      rv2 = $random(seed);
      {bx, bp} = rv;
      {si, di} = rv2;
      rv = $random(seed);
      rv2 = $random(seed);
      kind = (k < 32) ? k[4:3] : rv[27:26];
      rm = (k < 32) ? k[2:0] : rv[30:28];
      {mv, w, rg, hi, lo} = rv[20:0];
      axiWrite(`OAD_OFS_BASE, {16'h0, bx}, `OAD_RESP_OKAY);
      axiWrite(`OAD_OFS_FRAME, {16'h0, bp}, `OAD_RESP_OKAY);
      axiWrite(`OAD_OFS_SRCIDX, {16'h0, si}, `OAD_RESP_OKAY);
      axiWrite(`OAD_OFS_DSTIDX, {16'h0, di}, `OAD_RESP_OKAY);
      axiWrite(`OAD_OFS_CTRL, {29'h0, 1'b1, mv, w}, `OAD_RESP_OKAY);
      case (rm)
        3'h0: loc = bx + si;
        3'h1: loc = bx + di;
        3'h2: loc = bp + si;
        3'h3: loc = bp + di;
        3'h4: loc = si;
        3'h5: loc = di;
        3'h6: loc = bp;
        default: loc = bx;
      endcase
      loc = loc + ((kind == 2'h1) ? {{8{lo[7]}}, lo} : (kind == 2'h2) ? {hi, lo} : 16'h0);
      nb = (kind == 2'h3) ? 2'h0 : (kind == 2'h0) ? ((rm == 3'h6) ? 2'h2 : 2'h0) : kind;
      if (kind == 2'h0 && rm == 3'h6) loc = {hi, lo};
      if (kind == 2'h3) loc = 16'h0;
      ill = mv && rg[1:0] == 2'h1;
      push(rv2[7:0]);
      push({kind, rg, rm});
      if (nb > 2'h0) push(lo);
      if (nb > 2'h1) push(hi);
      // trailing immediate byte must leave the decode alone
      push(rv2[15:8]);
      repeat (2) @(posedge sys_clk);
      check(rmRegSel, (kind == 2'h3) ? 16'h1 << {~w, rm} : 16'h0, "rmSel");
      check(regFieldSel, 16'h1 << {~w, rg}, "regSel");
      check(segSel, 4'h1 << rg[1:0], "segSel");
      check(illegalInstr, ill, "illegal");
      axiRead(`OAD_OFS_RESULT, {2'h0, 11'h0, ill, nb, 1'b1, kind == 2'h3, loc});
      axiRead(`OAD_OFS_DECODE, {2'h0, 4'h0, 4'h1 << rg[1:0], kind, rg, rm, (nb > 2'h1) ? hi : 8'h0, (nb > 2'h0) ? lo : 8'h0});
    end
    $display("test decode done");
    repeat (2) @(posedge sys_clk);
    end_sim;
  end
endmodule
